// file: rtl/svm_pkg.sv
// Constants for the supply voltage monitor control block.
// Assumes an 8-bit internal bus with 20-bit addresses and a 100 MHz clock.
//
// Summary of operation
// - Reset and interrupt follow comparator, threshold and mode.
// - Other resets clear control register to 00h; detector reset keeps it.
// - Comparison flag and mask status bits are read-only.
// - Control bit 7 enables (1) or blocks (0) level register writes.
// - Mask status 1 while rewrite enabled or settling, combined mode only.
// - Comparison flag is 1 when supply is below threshold, else 0 or off.
// - Both registers take single-bit and whole-byte writes.
// - Level register bit 7 selects mode: 0 interrupt, 1 reset.
// - Level register bit 0 selects threshold: 0 upper, 1 lower or single.
// - Non-detector reset loads level register 00h, 81h or 01h by mode.
// - Combined mode: hardware updates mode and level bits on reset or irq.
// - Option byte: select 7:5, bit 4 one, level 3:2, mode 1:0.
// - Reset mode pair 1,1 takes seven select patterns, one threshold.
// - Combined mode pair 1,0 takes six select patterns, threshold pairs.
// - Interrupt mode pair 0,1 interrupts and releases initial reset.
// - After interrupt in combined mode, level and mode bits are set to 1.

package svm_pkg;

  localparam logic [19:0] ADDR_OPTION  = 20'h000c1;
  localparam logic [19:0] ADDR_CONTROL = 20'hfffa9;
  localparam logic [19:0] ADDR_LEVEL   = 20'hfffaa;

  // Control register fields
  localparam int          CTL_REWRITE_EN_POS = 7;
  localparam int          CTL_MASK_POS       = 1;
  localparam int          CTL_FLAG_POS       = 0;
  localparam logic [7:0]  CTL_RESET_VALUE    = 8'h00;

  // Level register fields and reset values per option mode
  localparam int          LVL_MODE_POS    = 7;
  localparam int          LVL_LEVEL_POS   = 0;
  localparam logic [7:0]  LVL_RESET_COMB  = 8'h00;
  localparam logic [7:0]  LVL_RESET_RST   = 8'h81;
  localparam logic [7:0]  LVL_RESET_INT   = 8'h01;

  // Option byte fields
  localparam int          OPT_SEL_HI       = 7;
  localparam int          OPT_SEL_LO       = 5;
  localparam int          OPT_ONE_POS      = 4;
  localparam int          OPT_LVL_HI       = 3;
  localparam int          OPT_LVL_LO       = 2;
  localparam int          OPT_MODE_HI      = 1;
  localparam int          OPT_MODE_LO      = 0;
  localparam logic [1:0]  OPT_MODE_COMB    = 2'h2;
  localparam logic [1:0]  OPT_MODE_RESET   = 2'h3;
  localparam logic [1:0]  OPT_MODE_INT     = 2'h1;

  // Threshold settling wait after an interrupt or a level change
  localparam int          CLOCK_PERIOD_NS  = 10;
  localparam int          SETTLE_TIME_NS   = 10000;
  localparam int          SETTLE_CYCLES    =
    (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int          SETTLE_W         = 11;

  typedef enum logic [1:0] {
    SVM_ST_INIT,
    SVM_ST_RUN,
    SVM_ST_RESET
  } svm_state_t;

endpackage : svm_pkg

// file: rtl/svm_settle_timer.sv
// Settling wait timer for the detection threshold.
// Assumes a one-cycle start pulse; restarts if pulsed while running.
`timescale 1ns/10ps
`default_nettype none

module svm_settle_timer
  import svm_pkg::*;
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset,
  // Control
  input  wire logic i_start,
  output var  logic o_busy
);

  logic [SETTLE_W-1:0] count_r;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      count_r <= '0;
    end else if (i_start) begin
      count_r <= SETTLE_W'(SETTLE_CYCLES);
    end else if (count_r != '0) begin
      count_r <= count_r - SETTLE_W'(1);
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= i_start || (count_r > SETTLE_W'(1));
    end
  end

endmodule : svm_settle_timer

`default_nettype wire

// file: rtl/svm_monitor_ctrl.sv
// Control and status logic of the supply voltage monitor.
// Assumes a single-cycle CPU bus with byte and bit writes, an option
// byte held stable after reset, and a comparator level synchronous
// to i_clock. i_reset is every reset except the detector's own.
`timescale 1ns/10ps
`default_nettype none

module svm_monitor_ctrl
  import svm_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // CPU internal bus
  input  wire logic [19:0] i_addr,
  input  wire logic        i_wr_en,
  input  wire logic        i_bit_op,
  input  wire logic [2:0]  i_bit_pos,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_rd_en,
  output var  logic [7:0]  o_rd_data,
  // Option byte and analog side
  input  wire logic [7:0]  i_option_byte,
  input  wire logic        i_below_threshold,
  output var  logic        o_threshold_level,
  output var  logic        o_detect_mode,
  // Reset and interrupt
  output var  logic        o_detector_reset,
  output var  logic        o_supply_monitor_irq
);

  // Merge a byte write or a single-bit write into an old value
  function automatic logic [7:0] merge_write(
    input logic [7:0] old_val,
    input logic       bit_op,
    input logic [2:0] pos,
    input logic [7:0] data
  );
    logic [7:0] res;
    res = old_val;
    if (bit_op) begin
      res[pos] = data[0];
    end else begin
      res = data;
    end
    return res;
  endfunction : merge_write

  logic [1:0] opt_mode;
  logic       det_off;
  logic       comb_mode;
  logic       below_r;
  logic       flag;
  logic       rewrite_en_r;
  logic       mode_bit_r;
  logic       level_bit_r;
  logic       settle_busy;
  logic       mask;
  logic       settle_start;
  logic       irq_event;
  logic       rst_event;
  logic       below_d_r;
  logic       ctl_wr;
  logic       lvl_wr;
  logic [7:0] ctl_wval;
  logic [7:0] lvl_wval;
  logic [7:0] lvl_init;
  svm_state_t state_r;

  assign opt_mode  = i_option_byte[OPT_MODE_HI:OPT_MODE_LO];
  // Option mode bits 0,1 (bit 0 set, bit 1 clear) with top select bit set means detector off
  assign det_off   = i_option_byte[OPT_SEL_HI]
                     && i_option_byte[OPT_MODE_LO]
                     && !i_option_byte[OPT_MODE_HI];
  assign comb_mode = (opt_mode == OPT_MODE_COMB);
  assign flag      = below_r && !det_off;
  assign mask      = comb_mode && (rewrite_en_r || settle_busy);

  assign ctl_wr   = i_wr_en && (i_addr == ADDR_CONTROL);
  assign lvl_wr   = i_wr_en && (i_addr == ADDR_LEVEL)
                    && rewrite_en_r;
  // Old enable kept so a bit write to a read-only bit leaves it alone
  assign ctl_wval = merge_write({rewrite_en_r, 7'h00}, i_bit_op, i_bit_pos,
                                i_wr_data);
  assign lvl_wval = merge_write({mode_bit_r, 6'h00, level_bit_r},
                                i_bit_op, i_bit_pos, i_wr_data);

  always_comb begin
    case (opt_mode)
      OPT_MODE_COMB:  lvl_init = LVL_RESET_COMB;
      OPT_MODE_RESET: lvl_init = LVL_RESET_RST;
      default:        lvl_init = LVL_RESET_INT;
    endcase
  end

  // Comparator sampled once so every consumer sees the same value
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      // Start as below so the reset holds until the supply is seen above
      below_r   <= 1'b1;
      below_d_r <= 1'b1;
    end else begin
      below_r   <= i_below_threshold;
      below_d_r <= below_r;
    end
  end

  // Events only outside the mask and never while the detector is off
  always_comb begin
    irq_event = 1'b0;
    rst_event = 1'b0;
    if ((state_r == SVM_ST_RUN) && !det_off && !mask) begin
      if (opt_mode == OPT_MODE_INT) begin
        irq_event = (below_r != below_d_r);
      end else if (mode_bit_r) begin
        rst_event = below_r;
      end else begin
        irq_event = below_r && !below_d_r;
      end
    end
  end

  assign settle_start = (irq_event && comb_mode)
                        || (lvl_wr && (lvl_wval[LVL_LEVEL_POS]
                                       != level_bit_r));

  svm_settle_timer u_settle (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_start (settle_start),
    .o_busy  (settle_busy)
  );

  // Detector reset sequencing; the detector reset does not touch regs
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_r <= SVM_ST_INIT;
    end else begin
      case (state_r)
        SVM_ST_INIT: begin
          if (det_off || !below_r) begin
            state_r <= SVM_ST_RUN;
          end
        end
        SVM_ST_RUN: begin
          if (rst_event) begin
            state_r <= SVM_ST_RESET;
          end
        end
        SVM_ST_RESET: begin
          if (!below_r) begin
            state_r <= SVM_ST_RUN;
          end
        end
        default: state_r <= SVM_ST_INIT;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_detector_reset <= 1'b1;
    end else begin
      o_detector_reset <= !det_off
        && ((state_r == SVM_ST_INIT && below_r)
            || (state_r == SVM_ST_RESET && below_r)
            || rst_event);
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_supply_monitor_irq <= 1'b0;
    end else begin
      o_supply_monitor_irq <= irq_event;
    end
  end

  // Control register: only the rewrite enable is stored
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rewrite_en_r <= CTL_RESET_VALUE[CTL_REWRITE_EN_POS];
    end else if (ctl_wr) begin
      rewrite_en_r <= ctl_wval[CTL_REWRITE_EN_POS];
    end
  end

  // Level register; hardware updates win over a same-cycle write
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      mode_bit_r  <= 1'b0;
      level_bit_r <= 1'b0;
    end else if (state_r == SVM_ST_INIT) begin
      // Option-dependent value loaded after release, not under reset
      mode_bit_r  <= lvl_init[LVL_MODE_POS];
      level_bit_r <= lvl_init[LVL_LEVEL_POS];
    end else if (comb_mode && irq_event) begin
      mode_bit_r  <= 1'b1;
      level_bit_r <= 1'b1;
    end else if (comb_mode && rst_event) begin
      // Release then waits for the upper threshold
      mode_bit_r  <= 1'b1;
      level_bit_r <= 1'b0;
    end else if (lvl_wr) begin
      mode_bit_r  <= lvl_wval[LVL_MODE_POS];
      level_bit_r <= lvl_wval[LVL_LEVEL_POS];
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_threshold_level <= 1'b0;
      o_detect_mode     <= 1'b0;
    end else begin
      o_threshold_level <= level_bit_r;
      o_detect_mode     <= mode_bit_r;
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr)
        ADDR_CONTROL: o_rd_data <= {rewrite_en_r, 5'h00, mask,
                                    flag};
        ADDR_LEVEL:   o_rd_data <= {mode_bit_r, 6'h00, level_bit_r};
        ADDR_OPTION:  o_rd_data <= i_option_byte;
        default:      o_rd_data <= 8'h00;
      endcase
    end
  end

endmodule : svm_monitor_ctrl

`default_nettype wire

// file: test/svm_comp_model.sv
// Comparator model for the analog side of the supply monitor.
// Assumes the bench sets the supply level in millivolts.
`timescale 1ns/10ps
`default_nettype none

module svm_comp_model #(
  parameter int HI_MV = 3000,
  parameter int LO_MV = 2550
) (
  // Analog side
  input  wire logic        i_level,
  input  wire logic [15:0] i_supply_mv,
  output var  logic        o_below
);
  // Live level, no hysteresis, so a slow ramp cannot hide a glitch
  always_comb o_below = i_supply_mv < (i_level ? LO_MV : HI_MV);
endmodule : svm_comp_model

`default_nettype wire

// file: test/svm_ctrl_asserts.sv
// Port checker for the supply monitor control block.
// Assumes it is bound to svm_monitor_ctrl and sees its ports only.
`timescale 1ns/10ps
`default_nettype none

module svm_ctrl_asserts
  import svm_pkg::*;
(
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_reset,
  // Bus
  input wire logic [19:0] i_addr,
  input wire logic        i_rd_en,
  input wire logic [7:0]  o_rd_data,
  // Detector
  input wire logic [7:0]  i_option_byte,
  input wire logic        i_below_threshold,
  input wire logic        o_threshold_level,
  input wire logic        o_detect_mode,
  input wire logic        o_detector_reset,
  input wire logic        o_supply_monitor_irq
);
  logic comb_m;
  logic rst_m;
  logic int_m;
  assign comb_m = i_option_byte[1:0] == OPT_MODE_COMB;
  assign rst_m  = i_option_byte[1:0] == OPT_MODE_RESET;
  assign int_m  = i_option_byte[1:0] == OPT_MODE_INT && !i_option_byte[7];
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence s_ctl_rd;
    i_rd_en && i_addr == ADDR_CONTROL;
  endsequence
  sequence s_low3;
    !i_below_threshold [*3];
  endsequence
  a_irq_one_cycle: assert property (
    o_supply_monitor_irq |=> !o_supply_monitor_irq)
    else $error("irq wider than one cycle");
  a_irq_sets_bits: assert property (
    comb_m && o_supply_monitor_irq |=> o_threshold_level && o_detect_mode)
    else $error("level and mode not set after irq");
  a_flag_live: assert property (
    s_ctl_rd ##0 !i_option_byte[7]
      |=> o_rd_data[0] == $past(i_below_threshold, 2))
    else $error("comparison flag wrong");
  a_mask_enable: assert property (
    $past(i_rd_en && i_addr == ADDR_CONTROL) && comb_m && o_rd_data[7]
      |-> o_rd_data[1])
    else $error("mask clear while rewrite enabled");
  a_mask_other: assert property (
    s_ctl_rd ##0 !comb_m |=> !o_rd_data[1])
    else $error("mask set outside combined mode");
  a_int_irq: assert property (
    int_m && !o_detector_reset && $changed(i_below_threshold)
      |-> ##2 o_supply_monitor_irq)
    else $error("no irq on comparator change");
  a_rst_assert: assert property (
    rst_m && i_below_threshold ##1 i_below_threshold |=> o_detector_reset)
    else $error("no reset while below");
  a_rst_release: assert property (
    rst_m ##0 s_low3 |=> !o_detector_reset)
    else $error("reset held above threshold");
endmodule : svm_ctrl_asserts

bind svm_monitor_ctrl svm_ctrl_asserts u_chk (
  .i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
  .i_option_byte(i_option_byte), .i_below_threshold(i_below_threshold),
  .o_threshold_level(o_threshold_level), .o_detect_mode(o_detect_mode),
  .o_detector_reset(o_detector_reset),
  .o_supply_monitor_irq(o_supply_monitor_irq));

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the supply monitor control block.
// Assumes the comparator model on the analog side and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import svm_pkg::*;
;
  logic        i_clock   = 1'b0;
  logic        i_reset   = 1'b1;
  logic [19:0] i_addr    = '0;
  logic        i_wr_en   = 1'b0;
  logic        i_bit_op  = 1'b0;
  logic [2:0]  i_bit_pos = '0;
  logic [7:0]  i_wr_data = '0;
  logic        i_rd_en   = 1'b0;
  logic [7:0]  opt       = 8'h15;
  logic [15:0] supply    = 16'd2000;
  logic [7:0]  rdata;
  logic        below;
  logic        lvl;
  logic        dmode;
  logic        drst;
  logic        irq;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          cycles     = 0;
  always #5 i_clock = ~i_clock;
  svm_monitor_ctrl DUT (
    .i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
    .i_wr_en(i_wr_en), .i_bit_op(i_bit_op), .i_bit_pos(i_bit_pos),
    .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .o_rd_data(rdata),
    .i_option_byte(opt), .i_below_threshold(below),
    .o_threshold_level(lvl), .o_detect_mode(dmode),
    .o_detector_reset(drst), .o_supply_monitor_irq(irq));
  svm_comp_model CMP (.i_level(lvl), .i_supply_mv(supply), .o_below(below));
  // Whole run is about 1220 cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
  endtask : wt
  task automatic bus(input logic [19:0] a, input logic [7:0] d,
                     input logic w, input logic b, input logic [2:0] p);
    @(posedge i_clock);
    i_addr    <= a;
    i_wr_data <= d;
    i_bit_op  <= b;
    i_bit_pos <= p;
    i_wr_en   <= w;
    i_rd_en   <= !w;
    @(posedge i_clock);
    i_wr_en   <= 1'b0;
    i_rd_en   <= 1'b0;
    @(posedge i_clock);
  endtask : bus
  task automatic rd(input logic [19:0] a, input logic [7:0] e,
                    input string nm);
    bus(a, 8'h00, 1'b0, 1'b0, 3'h0);
    chk(nm, rdata, e);
  endtask : rd
  task automatic sv(input logic [15:0] v);
    @(posedge i_clock);
    supply <= v;
  endtask : sv
  task automatic irqs(input int n, input logic [7:0] e);
    logic [7:0] c;
    c = 8'h00;
    repeat (n) begin
      @(posedge i_clock);
      if (irq !== 1'b0) c++;
    end
    chk("irq count", c, e);
  endtask : irqs
  task automatic boot(input logic [7:0] o);
    @(posedge i_clock);
    opt     <= o;
    i_reset <= 1'b1;
    wt(16);
    i_reset <= 1'b0;
    wt(4);
  endtask : boot
  task automatic s_int();
    boot(8'h15);
    chk("held reset", {7'h0, drst}, 8'h01);
    rd(ADDR_LEVEL, LVL_RESET_INT, "level");
    rd(ADDR_CONTROL, 8'h01, "control");
    rd(ADDR_OPTION, 8'h15, "option");
    chk("mode out", {7'h0, dmode}, 8'h00);
    sv(16'd2800);
    wt(4);
    chk("released", {7'h0, drst}, 8'h00);
    sv(16'd2000);
    irqs(8, 8'h01);
    sv(16'd2800);
    irqs(8, 8'h01);
  endtask : s_int
  task automatic s_rst();
    sv(16'd2000);
    boot(8'h1f);
    chk("held reset", {7'h0, drst}, 8'h01);
    rd(ADDR_LEVEL, LVL_RESET_RST, "level");
    sv(16'd2800);
    wt(4);
    chk("released", {7'h0, drst}, 8'h00);
    chk("mode out", {7'h0, dmode}, 8'h01);
    sv(16'd2000);
    wt(4);
    chk("reset again", {7'h0, drst}, 8'h01);
  endtask : s_rst
  task automatic s_comb();
    sv(16'd3100);
    boot(8'h16);
    rd(ADDR_LEVEL, LVL_RESET_COMB, "level");
    rd(ADDR_CONTROL, CTL_RESET_VALUE, "control");
    sv(16'd2800);
    irqs(8, 8'h01);
    rd(ADDR_LEVEL, 8'h81, "level irq");
    rd(ADDR_CONTROL, 8'h02, "settle mask");
    wt(SETTLE_CYCLES);
    rd(ADDR_CONTROL, 8'h00, "settled");
    bus(ADDR_LEVEL, 8'h00, 1'b1, 1'b0, 3'h0);
    rd(ADDR_LEVEL, 8'h81, "locked level");
    sv(16'd2400);
    wt(4);
    chk("low reset", {7'h0, drst}, 8'h01);
    rd(ADDR_LEVEL, 8'h80, "level rst");
    sv(16'd3100);
    wt(4);
    chk("released", {7'h0, drst}, 8'h00);
    // Rewrite enable sets the mask, blocks irqs and opens level writes
    bus(ADDR_CONTROL, 8'h83, 1'b1, 1'b0, 3'h0);
    rd(ADDR_CONTROL, 8'h82, "byte write");
    bus(ADDR_CONTROL, 8'h00, 1'b1, 1'b1, 3'h1);
    rd(ADDR_CONTROL, 8'h82, "bit write ro");
    sv(16'd2800);
    irqs(8, 8'h00);
    bus(ADDR_LEVEL, 8'h00, 1'b1, 1'b0, 3'h0);
    rd(ADDR_LEVEL, 8'h00, "open level");
    sv(16'd3100);
    bus(ADDR_CONTROL, 8'h00, 1'b1, 1'b1, 3'h7);
    rd(ADDR_CONTROL, 8'h00, "bit write");
  endtask : s_comb
  // Detector switched off: no reset, no interrupt, flag reads zero
  task automatic s_off();
    boot(8'h95);
    sv(16'd2000);
    irqs(8, 8'h00);
    chk("off reset", {7'h0, drst}, 8'h00);
    rd(ADDR_CONTROL, 8'h00, "off flag");
  endtask : s_off
  initial begin
    s_int();
    s_rst();
    s_comb();
    s_off();
    results();
  end
endmodule : tb_top

`default_nettype wire
